// ---- logic/fcs_host.sv ----
// host controller driving a clockless parallel nor flash through its pins
`timescale 1ns/1ps
`default_nettype none
module fcs_host #(
  parameter int AW         = 21,
  parameter int DW         = 16,
  parameter int POLL_LIMIT = 1000000
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  // user command port
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire fcs_pkg::fcs_op_t       cmd_op,
  input  wire logic [AW-1:0]          cmd_addr,
  input  wire logic [DW-1:0]          cmd_data,
  input  wire logic                   cmd_defer_check,
  input  wire logic                   cmd_check_lock,
  output logic                        done,
  output logic                        error,
  output fcs_pkg::fcs_result_t        result_q,
  output logic [7:0]                  status_q,
  output logic                        timeout_q,
  // flash pins
  output logic [AW-1:0]               flash_addr,
  input  wire logic [DW-1:0]          flash_dq_in,
  output logic [DW-1:0]               flash_dq_out,
  output logic                        flash_dq_oe,
  output logic                        flash_ce_n,
  output logic                        flash_oe_n,
  output logic                        flash_we_n,
  output logic                        reset_powerdown_pin_n
);

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE  = 4'h1,
    ST_PRE   = 4'h3,
    ST_PRERD = 4'h2,
    ST_SETUP = 4'h6,
    ST_CONF  = 4'h7,
    ST_POLL  = 4'h5,
    ST_CHECK = 4'h4,
    ST_DONE  = 4'hc,
    ST_XRD   = 4'hd
  } fcs_state_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_READ  = 2'h3
  } fcs_bus_t;

  fcs_state_t          state_q;
  fcs_bus_t            bus_q;
  logic [7:0]          cnt_q;
  logic [31:0]         poll_q;
  logic                bus_done;
  fcs_pkg::fcs_op_t    op_q;
  logic [AW-1:0]       addr_q;
  logic [DW-1:0]       data_q;
  logic                defer_q;
  logic                lock_q;
  logic [DW-1:0]       dq_s1_q, dq_s2_q, dq_s3_q;
  logic                done_q;
  logic [15:0]         codes;

  // returns setup and confirm codes of a two-write operation
  function automatic logic [15:0] op_codes(input fcs_pkg::fcs_op_t op);
    case (op)
      fcs_pkg::OP_BLOCK_ERASE: op_codes = {fcs_pkg::CMD_BLOCK_ERASE, fcs_pkg::CMD_CONFIRM};
      fcs_pkg::OP_CHIP_ERASE:  op_codes = {fcs_pkg::CMD_CHIP_ERASE, fcs_pkg::CMD_CONFIRM};
      fcs_pkg::OP_WRITE:       op_codes = {fcs_pkg::CMD_WRITE_SETUP, 8'h00};
      fcs_pkg::OP_LOCK_SET:    op_codes = {fcs_pkg::CMD_LOCK_SETUP, fcs_pkg::CMD_LOCK_CONFIRM};
      fcs_pkg::OP_LOCK_CLEAR:  op_codes = {fcs_pkg::CMD_LOCK_SETUP, fcs_pkg::CMD_CONFIRM};
      default:                 op_codes = {fcs_pkg::CMD_READ_ARRAY, fcs_pkg::CMD_READ_ARRAY};
    endcase
  endfunction

  // decodes the full status check of an operation
  function automatic fcs_pkg::fcs_result_t decode(input logic [7:0] sr, input fcs_pkg::fcs_op_t op,
                                                  input logic chk_lock);
    logic [7:0] m;
    m = sr & fcs_pkg::STATUS_MASK;
    decode.supply_fail = m[fcs_pkg::SB_SUPPLY];
    decode.protect     = m[fcs_pkg::SB_PROTECT] & (chk_lock || op == fcs_pkg::OP_LOCK_SET ||
                                                   op == fcs_pkg::OP_LOCK_CLEAR);
    decode.seq_error   = m[fcs_pkg::SB_WRITE] & m[fcs_pkg::SB_ERASE];
    decode.erase_fail  = m[fcs_pkg::SB_ERASE] & ~decode.seq_error;
    decode.write_fail  = m[fcs_pkg::SB_WRITE] & ~decode.seq_error;
  endfunction

  // three stage sampler for the data pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else if (clk_en) begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // bus cycle engine: write pulses we, read holds oe until sampled data settles
  assign bus_done = (bus_q == BUS_WRITE && cnt_q == 8'(fcs_pkg::WE_CYC)) ||
                    (bus_q == BUS_READ && cnt_q >= 8'(fcs_pkg::RD_CYC + 3) && dq_s2_q == dq_s3_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else if (clk_en) begin
      // reset pin timing counts while the bus is idle
      if ((bus_q == BUS_IDLE && state_q != ST_RESET) || bus_done ||
          (state_q == ST_RESET && cnt_q == 8'(fcs_pkg::RESET_CYC)))
        cnt_q <= 8'h00;
      else
        cnt_q <= cnt_q + 8'h01;
    end
  end

  always_comb begin
    flash_ce_n  = (bus_q == BUS_IDLE);
    flash_we_n  = ~(bus_q == BUS_WRITE && cnt_q != 8'(fcs_pkg::WE_CYC));
    flash_oe_n  = ~(bus_q == BUS_READ);
    flash_dq_oe = (bus_q == BUS_WRITE);
    cmd_ready   = (state_q == ST_IDLE);
    done        = done_q;
    error       = |result_q;
    codes       = op_codes(op_q);
  end

  // command and pin sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q               <= ST_RESET;
      bus_q                 <= BUS_IDLE;
      op_q                  <= fcs_pkg::OP_READ_ARRAY;
      addr_q                <= '0;
      data_q                <= '0;
      defer_q               <= 1'b0;
      lock_q                <= 1'b0;
      flash_addr            <= '0;
      flash_dq_out          <= '0;
      status_q              <= 8'h00;
      result_q              <= '0;
      timeout_q             <= 1'b0;
      poll_q                <= '0;
      done_q                <= 1'b0;
      reset_powerdown_pin_n <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      case (state_q)
        // pulse reset pin to clear device status
        ST_RESET: begin
          if (cnt_q == 8'(fcs_pkg::RESET_CYC)) begin
            reset_powerdown_pin_n <= 1'b1;
            state_q               <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_valid) begin
            op_q      <= cmd_op;
            addr_q    <= cmd_addr;
            data_q    <= cmd_data;
            defer_q   <= cmd_defer_check;
            lock_q    <= cmd_check_lock;
            timeout_q <= 1'b0;
            poll_q    <= '0;
            flash_addr <= cmd_addr;
            bus_q     <= BUS_WRITE;
            case (cmd_op)
              fcs_pkg::OP_READ_ARRAY: begin
                flash_dq_out <= DW'(fcs_pkg::CMD_READ_ARRAY);
                state_q      <= ST_DONE;
              end
              fcs_pkg::OP_CLEAR_STAT: begin
                flash_dq_out <= DW'(fcs_pkg::CMD_CLEAR_STATUS);
                result_q     <= '0;
                state_q      <= ST_DONE;
              end
              fcs_pkg::OP_READ_XSTAT: begin
                flash_dq_out <= DW'(fcs_pkg::CMD_READ_STATUS);
                state_q      <= ST_XRD;
              end
              default: begin
                flash_dq_out <= DW'(fcs_pkg::CMD_READ_STATUS);
                state_q      <= ST_PRE;
              end
            endcase
          end
        end
        ST_PRE: if (bus_done) begin
          bus_q   <= BUS_READ;
          state_q <= ST_PRERD;
        end
        ST_PRERD: if (bus_done) begin
          status_q <= dq_s3_q[7:0] & fcs_pkg::STATUS_MASK;
          poll_q   <= poll_q + 32'h1;
          if (dq_s3_q[fcs_pkg::SB_READY]) begin
            bus_q        <= BUS_WRITE;
            flash_dq_out <= DW'(codes[15:8]);
            state_q      <= ST_SETUP;
          end else if (poll_q >= 32'(POLL_LIMIT)) begin
            timeout_q <= 1'b1;
            bus_q     <= BUS_IDLE;
            state_q   <= ST_DONE;
          end
        end
        ST_SETUP: if (bus_done) begin
          bus_q <= BUS_WRITE;
          // second write carries data for a write, else the confirm code, to same address
          if (op_q == fcs_pkg::OP_WRITE)
            flash_dq_out <= data_q;
          else
            flash_dq_out <= DW'(codes[7:0]);
          flash_addr <= addr_q;
          state_q    <= ST_CONF;
          poll_q     <= '0;
        end
        ST_CONF: if (bus_done) begin
          bus_q   <= BUS_READ;
          state_q <= ST_POLL;
        end
        ST_POLL: if (bus_done) begin
          status_q <= dq_s3_q[7:0] & fcs_pkg::STATUS_MASK;
          poll_q   <= poll_q + 32'h1;
          if (dq_s3_q[fcs_pkg::SB_READY]) begin
            bus_q   <= BUS_IDLE;
            state_q <= ST_CHECK;
          end else if (poll_q >= 32'(POLL_LIMIT)) begin
            timeout_q <= 1'b1;
            bus_q     <= BUS_IDLE;
            state_q   <= ST_DONE;
          end
        end
        ST_CHECK: begin
          // deferred check leaves sticky errors for later; chip erase always checked
          if (!defer_q || op_q == fcs_pkg::OP_CHIP_ERASE)
            result_q <= decode(status_q, op_q, lock_q);
          state_q <= ST_DONE;
        end
        ST_XRD: if (bus_done) begin
          if (bus_q == BUS_WRITE) begin
            bus_q <= BUS_READ;
          end else begin
            status_q <= dq_s3_q[7:0] & fcs_pkg::XSTAT_MASK;
            bus_q    <= BUS_IDLE;
            state_q  <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (bus_q == BUS_IDLE || bus_done) begin
            bus_q   <= BUS_IDLE;
            done_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          bus_q   <= BUS_IDLE;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : fcs_host
`default_nettype wire

// ---- shared/fcs_pkg.sv ----
// package for the flash command sequencer host controller
package fcs_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h30;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
  // status bit positions
  localparam int SB_READY   = 7;
  localparam int SB_ERASE   = 5;
  localparam int SB_WRITE   = 4;
  localparam int SB_SUPPLY  = 3;
  localparam int SB_PROTECT = 1;
  localparam int XSB_AVAIL  = 7;
  // masks that drop reserved bits
  localparam logic [7:0] STATUS_MASK = 8'hfe;
  localparam logic [7:0] XSTAT_MASK  = 8'h80;
  // bus timing in ns and cycles at 40 MHz
  localparam int CLK_NS      = 25;
  localparam int T_WE_NS     = 50;
  localparam int T_RD_NS     = 100;
  localparam int T_RESET_NS  = 100;
  localparam int WE_CYC      = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC      = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC   = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  // user operations
  typedef enum logic [2:0] {
    OP_BLOCK_ERASE = 3'h0,
    OP_CHIP_ERASE  = 3'h1,
    OP_WRITE       = 3'h2,
    OP_LOCK_SET    = 3'h3,
    OP_LOCK_CLEAR  = 3'h4,
    OP_READ_ARRAY  = 3'h5,
    OP_CLEAR_STAT  = 3'h6,
    OP_READ_XSTAT  = 3'h7
  } fcs_op_t;
  // outcome of the full status check
  typedef struct packed {
    logic seq_error;
    logic erase_fail;
    logic write_fail;
    logic supply_fail;
    logic protect;
  } fcs_result_t;
endpackage : fcs_pkg

// ---- dv/fcs_flash_model.sv ----
// behavioural flash device for the host bench
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
  parameter int DW = 16
) (
  // bus pins
  input  wire logic [DW-1:0] dq_w,
  output logic      [DW-1:0] dq_r,
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic          rp_n,
  // fault and speed control
  input  wire logic [7:0]    inj,
  input  wire logic [15:0]   busy_ns
);
  logic [7:0]    sr_q = 8'h80;
  logic [7:0]    pv_q = 8'h00;
  logic [7:0]    last_q;
  logic [7:0]    pend_q;
  logic          st_q = 1'b0;
  logic [DW-1:0] hold_q = '0;
  always @(negedge rp_n) begin
    sr_q = 8'h80;
    pv_q = 8'h00;
  end
  always @(posedge we_n) begin
    if (!ce_n && rp_n) begin
      last_q = dq_w[7:0];
      st_q = 1'b1;
      if (pv_q != 8'h00) begin
        pend_q = (pv_q inside {8'h40, 8'h10} || last_q == 8'hd0 && pv_q inside {8'h20, 8'h30, 8'h60}
                 || last_q == 8'h01 && pv_q == 8'h60) ? (inj & 8'h3e) : 8'h30;
        pv_q = 8'h00;
        sr_q[7] = 1'b0;
        fork
          #(busy_ns) sr_q = sr_q | pend_q | 8'h80;
        join_none
      end else if (last_q == 8'h50)
        sr_q = sr_q & 8'h80;
      else if (last_q == 8'hff)
        st_q = 1'b0;
      else if (last_q != 8'h70)
        pv_q = last_q;
    end
  end
  assign dq_r = (!ce_n && !oe_n && rp_n) ? (st_q ? DW'(sr_q | 8'h01) : DW'(16'hc3a5)) : ~hold_q;
  always @(dq_r) if (!ce_n && !oe_n) hold_q = dq_r;
endmodule // fcs_flash_model
`default_nettype wire

// ---- dv/fcs_host_monitor.sv ----
// port assertions for the host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_host_monitor #(
  parameter int AW = 21,
  parameter int DW = 16
) (
  // clock and user side
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 clk_en,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_ready,
  input wire logic                 done,
  input wire logic                 error,
  input wire fcs_pkg::fcs_result_t result_q,
  input wire logic [7:0]           status_q,
  input wire logic                 timeout_q,
  // flash pins
  input wire logic [AW-1:0]        flash_addr,
  input wire logic [DW-1:0]        flash_dq_out,
  input wire logic                 flash_dq_oe,
  input wire logic                 flash_ce_n,
  input wire logic                 flash_oe_n,
  input wire logic                 flash_we_n,
  input wire logic                 reset_powerdown_pin_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_we_pulse;
    !flash_we_n [*2] ##1 flash_we_n;
  endsequence
  sequence s_take;
    clk_en && cmd_valid && cmd_ready;
  endsequence
  a_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_we_drives: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe without select or data");
  a_read_float: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
    else $error("read with data driven");
  a_write_held: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in write");
  a_pin_low: assert property ($rose(resetn) |-> !reset_powerdown_pin_n [*4])
    else $error("reset pin released early");
  a_pin_quiet: assert property (!reset_powerdown_pin_n |-> flash_we_n && flash_ce_n)
    else $error("bus active while pin low");
  a_done_once: assert property (done |-> cmd_ready ##1 !done)
    else $error("done not a single pulse");
  a_error_sum: assert property (error == (|result_q))
    else $error("error flag not result or");
  a_bit0_mask: assert property ($changed(status_q) |-> !status_q[0])
    else $error("reserved status bit kept");
  a_to_clear: assert property (s_take |=> !timeout_q)
    else $error("timeout not cleared on take");
endmodule // fcs_host_monitor
bind fcs_host fcs_host_monitor #(.AW(AW), .DW(DW)) u_mon (.clk, .resetn, .clk_en, .cmd_valid, .cmd_ready,
  .done, .error, .result_q, .status_q, .timeout_q, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .reset_powerdown_pin_n);
`default_nettype wire

// ---- dv/fcs_host_tb_top.sv ----
// self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_host_tb_top;
  localparam int AW = 21;
  localparam int DW = 16;
  typedef struct packed {logic [1:0] m; logic to; logic [4:0] r; logic [7:0] s;} fcs_exp_t;
  logic             clk = 1'b0;
  logic             resetn = 1'b0;
  logic             clk_en = 1'b1;
  logic             cmd_valid = 1'b0;
  logic [1:0]       dl = 2'b00;
  fcs_pkg::fcs_op_t cmd_op = fcs_pkg::OP_READ_ARRAY;
  logic [AW-1:0]    cmd_addr = '0;
  logic [DW-1:0]    cmd_data = '0;
  logic [7:0]       inj = 8'h00;
  logic [15:0]      busy_ns = 16'h0064;
  logic [31:0]      rnd = 32'heabf8b5d;
  wire logic        cmd_ready, done, error, timeout_q, dq_oe, ce_n, oe_n, we_n, rp_n;
  wire logic [7:0]  status_q;
  wire logic [4:0]  result_q;
  wire logic [AW-1:0] fa;
  wire logic [DW-1:0] dq_o, dev_q;
  wire logic [DW-1:0] dq = dq_oe ? dq_o : dev_q;
  fcs_exp_t q[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  fcs_host #(.AW(AW), .DW(DW), .POLL_LIMIT(20)) uut (.clk, .resetn, .clk_en, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_addr, .cmd_data, .cmd_defer_check(dl[1]), .cmd_check_lock(dl[0]), .done, .error,
    .result_q, .status_q, .timeout_q, .flash_addr(fa), .flash_dq_in(dq), .flash_dq_out(dq_o),
    .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_pin_n(rp_n));
  fcs_flash_model #(.DW(DW)) u_dev (.dq_w(dq), .dq_r(dev_q), .ce_n, .oe_n, .we_n, .rp_n, .inj, .busy_ns);
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic run(input fcs_pkg::fcs_op_t op, input logic [7:0] f, input logic [1:0] d, input fcs_exp_t e);
    @(posedge clk);
    #2;
    rnd = lfsr(rnd);
    cmd_op = op;
    inj = f;
    dl = d;
    cmd_addr = rnd[AW-1:0];
    cmd_data = rnd[31:16];
    busy_ns = e.to ? 16'h4e20 : 16'h0032 + {7'h00, rnd[8:0]};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    // one frozen edge: the request must not be taken
    clk_en = 1'b0;
    @(posedge clk);
    #2;
    chk("cmd_ready", 32'h0000_0001, 32'(cmd_ready));
    clk_en = 1'b1;
    @(posedge clk);
    q.push_back(e);
    #2;
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge clk);
  endtask
  task automatic clr();
    run(fcs_pkg::OP_CLEAR_STAT, 8'h00, 2'b00, {2'b10, 1'b0, 5'h00, 8'h00});
  endtask
  always @(negedge clk) begin : watch_p
    fcs_exp_t e;
    if (done === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : '1;
      if (e.m[1]) begin
        chk("result_q", 32'(e.r), 32'(result_q));
        chk("error", 32'(|e.r), 32'(error));
      end
      if (e.m[0]) chk("status_q", 32'(e.s), 32'(status_q));
      chk("timeout_q", 32'(e.to), 32'(timeout_q));
    end
  end
  // every strobe goes to the commanded address
  always @(posedge we_n) begin
    if (resetn === 1'b1 && ce_n === 1'b0) chk("flash_addr", 32'(cmd_addr), 32'(fa));
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #2 resetn = 1'b1;
    run(fcs_pkg::OP_BLOCK_ERASE, 8'h00, 2'b00, {2'b11, 1'b0, 5'h00, 8'h80});
    run(fcs_pkg::OP_BLOCK_ERASE, 8'h20, 2'b00, {2'b11, 1'b0, 5'h08, 8'ha0});
    run(fcs_pkg::OP_READ_XSTAT, 8'h00, 2'b00, {2'b01, 1'b0, 5'h00, 8'h80});
    clr();
    run(fcs_pkg::OP_WRITE, 8'h18, 2'b00, {2'b11, 1'b0, 5'h06, 8'h98});
    run(fcs_pkg::OP_WRITE, 8'h00, 2'b10, {2'b11, 1'b0, 5'h06, 8'h98});
    run(fcs_pkg::OP_WRITE, 8'h00, 2'b00, {2'b11, 1'b0, 5'h06, 8'h98});
    clr();
    run(fcs_pkg::OP_WRITE, 8'h02, 2'b00, {2'b11, 1'b0, 5'h00, 8'h82});
    run(fcs_pkg::OP_WRITE, 8'h00, 2'b01, {2'b11, 1'b0, 5'h01, 8'h82});
    clr();
    run(fcs_pkg::OP_LOCK_SET, 8'h10, 2'b00, {2'b11, 1'b0, 5'h04, 8'h90});
    clr();
    run(fcs_pkg::OP_LOCK_CLEAR, 8'h22, 2'b00, {2'b11, 1'b0, 5'h09, 8'ha2});
    clr();
    run(fcs_pkg::OP_CHIP_ERASE, 8'h28, 2'b10, {2'b11, 1'b0, 5'h0a, 8'ha8});
    clr();
    run(fcs_pkg::OP_BLOCK_ERASE, 8'h30, 2'b00, {2'b11, 1'b0, 5'h10, 8'hb0});
    @(posedge clk);
    #2 resetn = 1'b0;
    repeat (2) @(posedge clk);
    #2 resetn = 1'b1;
    run(fcs_pkg::OP_BLOCK_ERASE, 8'h00, 2'b00, {2'b11, 1'b0, 5'h00, 8'h80});
    run(fcs_pkg::OP_READ_ARRAY, 8'h00, 2'b00, {2'b00, 1'b0, 5'h00, 8'h00});
    chk("last command", 32'h0000_00ff, 32'(u_dev.last_q));
    repeat (3) run(fcs_pkg::OP_LOCK_SET, 8'h02, 2'b10, {2'b10, 1'b0, 5'h00, 8'h00});
    run(fcs_pkg::OP_LOCK_SET, 8'h00, 2'b00, {2'b11, 1'b0, 5'h01, 8'h82});
    run(fcs_pkg::OP_WRITE, 8'h00, 2'b00, {2'b00, 1'b1, 5'h00, 8'h00});
    summarize();
  end
endmodule // fcs_host_tb_top
`default_nettype wire
